/* File: pkg/sbm_pkg.sv */
// How it works
// - Every interface output comes from a flop
// - Processor end registers every interface input; agent end uses them directly
// - Master drives buses, strobes valid output
// - Slave: agent drives buses, strobes valid input
// - Master kept unless arbitration or read release
// - Agent requests only from its idle state
// - Agent asserts request line, awaits release
// - Release pulse lasts exactly one cycle
// - Master regained once external request issued
// - Read issue cycle releases the bus itself
// - After self release, next request restores master
// - Agent sees self release, drives both buses
// - In slave, agent starts one unarbitrated request
// - No second read until response arrives
// - Legacy writes: four cycles before next request
// - Fast write modes: next write at once
// - Processor requests are reads or writes only
// - One pending request; writes need no read
// - Ready inputs pace reads and writes
// - Ready two cycles before makes issue cycle
// - Address cycle repeats until issued
// - Command bit 8 marks address or data
package sbm_pkg;

    localparam int SBM_AD_W = 64;
    localparam int SBM_CMD_W = 9;
    localparam int SBM_CMD_CYCLE_BIT = 8;
    localparam int SBM_CMD_WR_BIT = 7;
    localparam int SBM_DATA_LAST_BIT = 7;
    localparam logic SBM_ADDR_CYCLE = 1'h0;
    localparam logic SBM_DATA_CYCLE = 1'h1;
    // Data identifier for a single, final data word
    localparam logic [7:0] SBM_DATA_ID_LAST = 8'h80;

    // Legacy write spacing, counted from the issue cycle
    localparam int SBM_WR_SPACING = 4;
    localparam int SBM_GAP_W = 2;
    // Issue and data cycle already cover part of the spacing
    localparam logic [SBM_GAP_W-1:0] SBM_GAP_LOAD = SBM_GAP_W'(SBM_WR_SPACING - 3);

    typedef enum logic [1:0] {
        SBM_WM_COMPAT = 2'h0,
        SBM_WM_REISSUE = 2'h1,
        SBM_WM_PIPE = 2'h2
    } sbm_wmode_t;

    typedef enum logic [2:0] {
        SBM_P_IDLE = 3'h0,
        SBM_P_ADDR = 3'h1,
        SBM_P_WDATA = 3'h3,
        SBM_P_GAP = 3'h2,
        SBM_P_SLAVE = 3'h6
    } sbm_pstate_t;

    typedef enum logic [1:0] {
        SBM_A_IDLE = 2'h0,
        SBM_A_ARB = 2'h1,
        SBM_A_SLAVE = 2'h3,
        SBM_A_WDATA = 2'h2
    } sbm_astate_t;

endpackage

/* File: pkg/sbm_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sbm_bus_if #(parameter int AD_W = sbm_pkg::SBM_AD_W);
    logic [AD_W-1:0] proc_ad;
    logic [sbm_pkg::SBM_CMD_W-1:0] proc_cmd;
    logic proc_oe;
    logic proc_valid_n;
    logic release_n;
    logic [AD_W-1:0] agent_ad;
    logic [sbm_pkg::SBM_CMD_W-1:0] agent_cmd;
    logic agent_oe;
    logic agent_valid_n;
    logic ext_request_n;
    logic read_ready_n;
    logic write_ready_n;
    logic [AD_W-1:0] sys_addr_data_bus;
    logic [sbm_pkg::SBM_CMD_W-1:0] sys_command_bus;

    // Shared wires resolved from the enables; idle bus reads as zero
    assign sys_addr_data_bus = proc_oe ? proc_ad : (agent_oe ? agent_ad : '0);
    assign sys_command_bus = proc_oe ? proc_cmd : (agent_oe ? agent_cmd : '0);

    modport proc (
        output proc_ad, proc_cmd, proc_oe, proc_valid_n, release_n,
        input sys_addr_data_bus, sys_command_bus, agent_valid_n, ext_request_n, read_ready_n, write_ready_n
    );
    modport agent (
        output agent_ad, agent_cmd, agent_oe, agent_valid_n, ext_request_n, read_ready_n, write_ready_n,
        input sys_addr_data_bus, sys_command_bus, proc_valid_n, release_n
    );
endinterface
`default_nettype wire

/* File: rtl/sbm_proc_end.sv */
`timescale 1ns/1ps
`default_nettype none
module sbm_proc_end import sbm_pkg::*; #(
    parameter int AD_W = SBM_AD_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Boot-time write mode, taken while reset is high
    input wire sbm_wmode_t i_write_mode,
    // Core request
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [7:0] i_req_cmd,
    input wire logic [AD_W-1:0] i_req_addr,
    input wire logic [AD_W-1:0] i_req_wdata,
    output logic o_req_taken,
    // Results
    output logic [AD_W-1:0] o_rd_data,
    output logic o_rd_valid,
    output logic [AD_W-1:0] o_ext_wr_data,
    output logic o_ext_wr_valid,
    output logic o_master,
    output logic o_rd_pending,
    // System interface
    sbm_bus_if.proc bus
);

    typedef struct packed {
        sbm_pstate_t st;
        logic master;
        logic [AD_W-1:0] ad;
        logic [SBM_CMD_W-1:0] cmd;
        logic oe;
        logic valid_n;
        logic release_n;
        logic ext_n;
        logic rrdy_n;
        logic rrdy_d_n;
        logic wrdy_n;
        logic wrdy_d_n;
        logic avalid_n;
        logic [AD_W-1:0] ad_in;
        logic [SBM_CMD_W-1:0] cmd_in;
        logic is_write;
        logic held;
        logic rd_pend;
        logic took_addr;
        logic [AD_W-1:0] wdata;
        logic [SBM_GAP_W-1:0] gap;
        sbm_wmode_t wmode;
        logic req_taken;
        logic [AD_W-1:0] rd_data;
        logic rd_valid;
        logic [AD_W-1:0] ext_data;
        logic ext_valid;
    } sbm_proc_reg_t;

    sbm_proc_reg_t s_r;
    sbm_proc_reg_t s_nxt;
    logic issue;
    logic ready_next;
    logic free;
    logic done;

    always_comb begin
        s_nxt = s_r;
        done = 1'b0;
        s_nxt.ext_n = bus.ext_request_n;
        s_nxt.rrdy_n = bus.read_ready_n;
        s_nxt.rrdy_d_n = s_r.rrdy_n;
        s_nxt.wrdy_n = bus.write_ready_n;
        s_nxt.wrdy_d_n = s_r.wrdy_n;
        s_nxt.avalid_n = bus.agent_valid_n;
        s_nxt.ad_in = bus.sys_addr_data_bus;
        s_nxt.cmd_in = bus.sys_command_bus;
        s_nxt.release_n = 1'b1;
        s_nxt.req_taken = 1'b0;
        s_nxt.rd_valid = 1'b0;
        s_nxt.ext_valid = 1'b0;
        // Ready seen two cycles before the address cycle
        issue = s_r.is_write ? !s_r.wrdy_d_n : !s_r.rrdy_d_n;
        ready_next = s_r.is_write ? !s_r.wrdy_n : !s_r.rrdy_n;
        // Legacy mode waits out the gap, fast modes do not
        free = (s_r.st == SBM_P_IDLE) || (s_r.st == SBM_P_GAP && s_r.gap == '0)
            || (s_r.st == SBM_P_WDATA && s_r.wmode != SBM_WM_COMPAT);

        unique case (s_r.st)
            SBM_P_IDLE: begin
            end
            SBM_P_ADDR: begin
                if (issue) begin
                    if (s_r.is_write) begin
                        // Data cycle marked in the top command bit
                        s_nxt.st = SBM_P_WDATA;
                        s_nxt.ad = s_r.wdata;
                        s_nxt.cmd = {SBM_DATA_CYCLE, SBM_DATA_ID_LAST};
                    end else begin
                        s_nxt.st = SBM_P_SLAVE;
                        s_nxt.rd_pend = 1'b1;
                        s_nxt.oe = 1'b0;
                        s_nxt.valid_n = 1'b1;
                    end
                end else if (!s_r.ext_n && !ready_next) begin
                    // Arbitration wins while not about to issue; request retried later
                    s_nxt.release_n = 1'b0;
                    s_nxt.held = 1'b1;
                    s_nxt.st = SBM_P_SLAVE;
                    s_nxt.oe = 1'b0;
                    s_nxt.valid_n = 1'b1;
                end
                // Otherwise the address cycle simply repeats
            end
            SBM_P_WDATA: begin
                s_nxt.valid_n = 1'b1;
                s_nxt.st = (s_r.wmode == SBM_WM_COMPAT) ? SBM_P_GAP : SBM_P_IDLE;
                s_nxt.gap = SBM_GAP_LOAD;
            end
            SBM_P_GAP: begin
                if (s_r.gap != '0) begin
                    s_nxt.gap = s_r.gap - 1'b1;
                end else begin
                    s_nxt.st = SBM_P_IDLE;
                end
            end
            SBM_P_SLAVE: begin
                if (!s_r.avalid_n) begin
                    if (s_r.cmd_in[SBM_CMD_CYCLE_BIT] == SBM_ADDR_CYCLE) begin
                        if (s_r.cmd_in[SBM_CMD_WR_BIT]) begin
                            s_nxt.took_addr = 1'b1;
                        end else begin
                            done = 1'b1;
                        end
                    end else if (s_r.took_addr) begin
                        s_nxt.ext_data = s_r.ad_in;
                        s_nxt.ext_valid = 1'b1;
                        done = 1'b1;
                    end else begin
                        s_nxt.rd_data = s_r.ad_in;
                        s_nxt.rd_valid = 1'b1;
                        if (s_r.cmd_in[SBM_DATA_LAST_BIT]) begin
                            s_nxt.rd_pend = 1'b0;
                            done = 1'b1;
                        end
                    end
                end
                if (done) begin
                    // Back to master right after the external request
                    s_nxt.took_addr = 1'b0;
                    s_nxt.oe = 1'b1;
                    s_nxt.held = 1'b0;
                    s_nxt.st = s_r.held ? SBM_P_ADDR : SBM_P_IDLE;
                    s_nxt.valid_n = !s_r.held;
                end
            end
            default: begin
                s_nxt.st = SBM_P_IDLE;
            end
        endcase

        if (free) begin
            if (!s_r.ext_n) begin
                // Grant to the agent from a free master: idle, gap over, or fast-mode data cycle
                s_nxt.release_n = 1'b0;
                s_nxt.st = SBM_P_SLAVE;
                s_nxt.oe = 1'b0;
                s_nxt.valid_n = 1'b1;
            // Nothing new while a read is pending
            end else if (i_req_valid && !s_r.rd_pend) begin
                // Read or write command in an address cycle
                s_nxt.req_taken = 1'b1;
                s_nxt.st = SBM_P_ADDR;
                s_nxt.is_write = i_req_write;
                s_nxt.ad = i_req_addr;
                s_nxt.wdata = i_req_wdata;
                s_nxt.cmd = {SBM_ADDR_CYCLE, i_req_write, i_req_cmd[SBM_CMD_WR_BIT-1:0]};
                // Valid strobe with every valid address
                s_nxt.valid_n = 1'b0;
            end
        end

        // Predict a read issue one cycle ahead to pulse release in it
        if (s_nxt.st == SBM_P_ADDR && !s_nxt.is_write && !s_r.rrdy_n) begin
            s_nxt.release_n = 1'b0;
        end
        s_nxt.master = (s_nxt.st != SBM_P_SLAVE);

        if (i_reset) begin
            s_nxt = '0;
            s_nxt.st = SBM_P_IDLE;
            s_nxt.master = 1'b1;
            s_nxt.oe = 1'b1;
            s_nxt.valid_n = 1'b1;
            s_nxt.release_n = 1'b1;
            s_nxt.ext_n = 1'b1;
            s_nxt.rrdy_n = 1'b1;
            s_nxt.rrdy_d_n = 1'b1;
            s_nxt.wrdy_n = 1'b1;
            s_nxt.wrdy_d_n = 1'b1;
            s_nxt.avalid_n = 1'b1;
            s_nxt.wmode = i_write_mode;
        end
    end

    always_ff @(posedge i_clock) begin
        s_r <= s_nxt;
    end

    // Pins straight from flops; drivers off in slave state
    assign bus.proc_ad = s_r.ad;
    assign bus.proc_cmd = s_r.cmd;
    assign bus.proc_oe = s_r.oe;
    assign bus.proc_valid_n = s_r.valid_n;
    assign bus.release_n = s_r.release_n;
    assign o_req_taken = s_r.req_taken;
    assign o_rd_data = s_r.rd_data;
    assign o_rd_valid = s_r.rd_valid;
    assign o_ext_wr_data = s_r.ext_data;
    assign o_ext_wr_valid = s_r.ext_valid;
    assign o_master = s_r.master;
    assign o_rd_pending = s_r.rd_pend;

endmodule
`default_nettype wire

/* File: rtl/sbm_agent_end.sv */
`timescale 1ns/1ps
`default_nettype none
module sbm_agent_end import sbm_pkg::*; #(
    parameter int AD_W = SBM_AD_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Flow control for processor requests
    input wire logic i_read_accept,
    input wire logic i_write_accept,
    // External request to send
    input wire logic i_ext_valid,
    input wire logic i_ext_write,
    input wire logic [7:0] i_ext_cmd,
    input wire logic [AD_W-1:0] i_ext_addr,
    input wire logic [AD_W-1:0] i_ext_data,
    output logic o_ext_taken,
    // Read response to send
    input wire logic i_rsp_valid,
    input wire logic [AD_W-1:0] i_rsp_data,
    output logic o_rsp_taken,
    // Processor requests seen
    output logic o_preq_valid,
    output logic o_preq_write,
    output logic [AD_W-1:0] o_preq_addr,
    output logic [7:0] o_preq_cmd,
    output logic [AD_W-1:0] o_pwr_data,
    output logic o_pwr_valid,
    output logic o_rd_pending,
    // System interface
    sbm_bus_if.agent bus
);

    typedef struct packed {
        sbm_astate_t st;
        logic [AD_W-1:0] ad;
        logic [SBM_CMD_W-1:0] cmd;
        logic oe;
        logic valid_n;
        logic ext_n;
        logic rrdy_n;
        logic rrdy_h1_n;
        logic rrdy_h2_n;
        logic wrdy_n;
        logic wrdy_h1_n;
        logic wrdy_h2_n;
        logic rd_pend;
        logic wexp;
        logic [AD_W-1:0] wdata;
        logic ext_taken;
        logic rsp_taken;
        logic preq_valid;
        logic preq_write;
        logic [AD_W-1:0] preq_addr;
        logic [7:0] preq_cmd;
        logic [AD_W-1:0] pwr_data;
        logic pwr_valid;
    } sbm_agent_reg_t;

    sbm_agent_reg_t s_r;
    sbm_agent_reg_t s_nxt;
    logic pvalid;
    logic own;

    always_comb begin
        s_nxt = s_r;
        s_nxt.oe = 1'b0;
        s_nxt.valid_n = 1'b1;
        s_nxt.ext_taken = 1'b0;
        s_nxt.rsp_taken = 1'b0;
        s_nxt.preq_valid = 1'b0;
        s_nxt.pwr_valid = 1'b0;
        // Ready lines and their two-cycle history
        s_nxt.rrdy_n = !i_read_accept;
        s_nxt.rrdy_h1_n = s_r.rrdy_n;
        s_nxt.rrdy_h2_n = s_r.rrdy_h1_n;
        s_nxt.wrdy_n = !i_write_accept;
        s_nxt.wrdy_h1_n = s_r.wrdy_n;
        s_nxt.wrdy_h2_n = s_r.wrdy_h1_n;

        pvalid = !bus.proc_valid_n;
        // Address counts only if ready was low two cycles earlier
        if (pvalid && bus.sys_command_bus[SBM_CMD_CYCLE_BIT] == SBM_ADDR_CYCLE
            && !(bus.sys_command_bus[SBM_CMD_WR_BIT] ? s_r.wrdy_h2_n : s_r.rrdy_h2_n)) begin
            s_nxt.preq_valid = 1'b1;
            s_nxt.preq_write = bus.sys_command_bus[SBM_CMD_WR_BIT];
            s_nxt.preq_addr = bus.sys_addr_data_bus;
            s_nxt.preq_cmd = bus.sys_command_bus[7:0];
            if (bus.sys_command_bus[SBM_CMD_WR_BIT]) begin
                s_nxt.wexp = 1'b1;
            end else begin
                s_nxt.rd_pend = 1'b1;
            end
        end
        if (pvalid && bus.sys_command_bus[SBM_CMD_CYCLE_BIT] == SBM_DATA_CYCLE && s_r.wexp) begin
            s_nxt.pwr_data = bus.sys_addr_data_bus;
            s_nxt.pwr_valid = 1'b1;
            s_nxt.wexp = 1'b0;
        end

        unique case (s_r.st)
            SBM_A_IDLE: begin
                // Ask for the bus, hold until release
                if (i_ext_valid || (s_r.rd_pend && i_rsp_valid)) begin
                    s_nxt.st = SBM_A_ARB;
                    s_nxt.ext_n = 1'b0;
                end
            end
            SBM_A_ARB: begin
            end
            SBM_A_SLAVE: begin
            end
            SBM_A_WDATA: begin
                s_nxt.ad = s_r.wdata;
                s_nxt.cmd = {SBM_DATA_CYCLE, SBM_DATA_ID_LAST};
                s_nxt.oe = 1'b1;
                s_nxt.valid_n = 1'b0;
                s_nxt.st = SBM_A_IDLE;
            end
        endcase

        // Drive only once the bus is ours
        own = !bus.release_n || s_r.st == SBM_A_SLAVE;
        if (own) begin
            s_nxt.ext_n = 1'b1;
            s_nxt.st = SBM_A_SLAVE;
            if (i_ext_valid) begin
                // Agent strobes valid with its address
                s_nxt.ad = i_ext_addr;
                s_nxt.cmd = {SBM_ADDR_CYCLE, i_ext_write, i_ext_cmd[SBM_CMD_WR_BIT-1:0]};
                s_nxt.oe = 1'b1;
                s_nxt.valid_n = 1'b0;
                s_nxt.wdata = i_ext_data;
                s_nxt.ext_taken = 1'b1;
                s_nxt.st = i_ext_write ? SBM_A_WDATA : SBM_A_IDLE;
            end else if (s_nxt.rd_pend && i_rsp_valid) begin
                s_nxt.ad = i_rsp_data;
                s_nxt.cmd = {SBM_DATA_CYCLE, SBM_DATA_ID_LAST};
                s_nxt.oe = 1'b1;
                s_nxt.valid_n = 1'b0;
                s_nxt.rd_pend = 1'b0;
                s_nxt.rsp_taken = 1'b1;
                s_nxt.st = SBM_A_IDLE;
            end
        end

        if (i_reset) begin
            s_nxt = '0;
            s_nxt.st = SBM_A_IDLE;
            s_nxt.valid_n = 1'b1;
            s_nxt.ext_n = 1'b1;
            s_nxt.rrdy_n = 1'b1;
            s_nxt.rrdy_h1_n = 1'b1;
            s_nxt.rrdy_h2_n = 1'b1;
            s_nxt.wrdy_n = 1'b1;
            s_nxt.wrdy_h1_n = 1'b1;
            s_nxt.wrdy_h2_n = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        s_r <= s_nxt;
    end

    assign bus.agent_ad = s_r.ad;
    assign bus.agent_cmd = s_r.cmd;
    assign bus.agent_oe = s_r.oe;
    assign bus.agent_valid_n = s_r.valid_n;
    assign bus.ext_request_n = s_r.ext_n;
    assign bus.read_ready_n = s_r.rrdy_n;
    assign bus.write_ready_n = s_r.wrdy_n;
    assign o_ext_taken = s_r.ext_taken;
    assign o_rsp_taken = s_r.rsp_taken;
    assign o_preq_valid = s_r.preq_valid;
    assign o_preq_write = s_r.preq_write;
    assign o_preq_addr = s_r.preq_addr;
    assign o_preq_cmd = s_r.preq_cmd;
    assign o_pwr_data = s_r.pwr_data;
    assign o_pwr_valid = s_r.pwr_valid;
    assign o_rd_pending = s_r.rd_pend;

endmodule
`default_nettype wire

/* File: tb/sbm_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sbm_asserts import sbm_pkg::*; #(
    parameter int AD_W = SBM_AD_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Shared interface
    input wire logic proc_oe,
    input wire logic proc_valid_n,
    input wire logic release_n,
    input wire logic agent_oe,
    input wire logic agent_valid_n,
    input wire logic ext_request_n,
    input wire logic read_ready_n,
    input wire logic write_ready_n,
    input wire logic [AD_W-1:0] sys_addr_data_bus,
    input wire logic [SBM_CMD_W-1:0] sys_command_bus
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    sequence s_addr;
        !proc_valid_n && proc_oe && sys_command_bus[SBM_CMD_CYCLE_BIT] == SBM_ADDR_CYCLE;
    endsequence
    sequence s_rd_addr;
        s_addr ##0 !sys_command_bus[SBM_CMD_WR_BIT];
    endsequence
    sequence s_wr_addr;
        s_addr ##0 sys_command_bus[SBM_CMD_WR_BIT];
    endsequence

    property p_release_one;
        $fell(release_n) |=> release_n;
    endproperty
    a_release_one: assert property (p_release_one) else $error("release pulse too long");
    property p_no_fight;
        !(proc_oe && agent_oe);
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("both ends drive the bus");
    property p_off_after_release;
        !release_n |=> !proc_oe && proc_valid_n;
    endproperty
    a_off_after_release: assert property (p_off_after_release) else $error("processor drives in slave");
    property p_valid_master;
        !proc_valid_n |-> proc_oe;
    endproperty
    a_valid_master: assert property (p_valid_master) else $error("valid strobe without drive");
    property p_agent_valid;
        !agent_valid_n |-> agent_oe && !proc_oe;
    endproperty
    a_agent_valid: assert property (p_agent_valid) else $error("agent strobe without drive");
    property p_release_cause;
        !release_n && $past(ext_request_n, 2) |-> s_rd_addr;
    endproperty
    a_release_cause: assert property (p_release_cause) else $error("release without cause");
    property p_read_issue;
        s_rd_addr ##0 $past(ext_request_n, 2) |-> release_n == $past(read_ready_n, 2);
    endproperty
    a_read_issue: assert property (p_read_issue) else $error("read release off its issue cycle");
    property p_write_data;
        s_wr_addr ##0 !$past(write_ready_n, 2) |=>
            !proc_valid_n && sys_command_bus == {SBM_DATA_CYCLE, SBM_DATA_ID_LAST};
    endproperty
    a_write_data: assert property (p_write_data) else $error("no data after write issue");
    property p_addr_repeat;
        s_addr ##0 release_n && (sys_command_bus[SBM_CMD_WR_BIT] ? $past(write_ready_n, 2) : $past(read_ready_n, 2))
            |=> !release_n || (!proc_valid_n && $stable(sys_command_bus) && $stable(sys_addr_data_bus));
    endproperty
    a_addr_repeat: assert property (p_addr_repeat) else $error("address not repeated");
endmodule
`default_nettype wire

/* File: tb/sysbus_master_slave_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sysbus_master_slave_control_tb;
    import sbm_pkg::*;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    sbm_wmode_t wmode = SBM_WM_COMPAT;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [SBM_AD_W-1:0] req_addr = '0, req_wdata = '0, ext_data = '0, rsp_data = '0;
    logic rd_acc = 1'b1, wr_acc = 1'b1, ext_valid = 1'b0, rsp_valid = 1'b0;
    logic req_taken, rd_valid, pext_valid, master, prd_pend, ext_taken, rsp_taken;
    logic preq_valid, preq_write, pwr_valid, ard_pend;
    logic [SBM_AD_W-1:0] rd_data, pext_data, preq_addr, pwr_data, last_rd, last_wr, last_ext;
    logic [7:0] preq_cmd;
    int fails = 0, checks = 0, rel_cnt = 0, rd_cnt = 0, wr_cnt = 0, ext_cnt = 0, arb_cnt = 0;
    int k, r0, rl0, e0, w0, a0;
    time preq_t[$];
    sbm_wmode_t wm[3] = '{SBM_WM_COMPAT, SBM_WM_REISSUE, SBM_WM_PIPE};
    int gap[3] = '{SBM_WR_SPACING, 2, 2};

    sbm_bus_if #(.AD_W(SBM_AD_W)) u_sbm_bus_if ();
    sbm_proc_end #(.AD_W(SBM_AD_W)) u_sbm_proc_end (.i_clock(i_clock), .i_reset(i_reset), .i_write_mode(wmode),
        .i_req_valid(req_valid), .i_req_write(req_write), .i_req_cmd(8'h0F), .i_req_addr(req_addr),
        .i_req_wdata(req_wdata), .o_req_taken(req_taken), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_ext_wr_data(pext_data), .o_ext_wr_valid(pext_valid), .o_master(master), .o_rd_pending(prd_pend),
        .bus(u_sbm_bus_if));
    sbm_agent_end #(.AD_W(SBM_AD_W)) u_sbm_agent_end (.i_clock(i_clock), .i_reset(i_reset),
        .i_read_accept(rd_acc), .i_write_accept(wr_acc), .i_ext_valid(ext_valid), .i_ext_write(1'b1),
        .i_ext_cmd(8'h01), .i_ext_addr(64'h8), .i_ext_data(ext_data), .o_ext_taken(ext_taken),
        .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data), .o_rsp_taken(rsp_taken), .o_preq_valid(preq_valid),
        .o_preq_write(preq_write), .o_preq_addr(preq_addr), .o_preq_cmd(preq_cmd), .o_pwr_data(pwr_data),
        .o_pwr_valid(pwr_valid), .o_rd_pending(ard_pend), .bus(u_sbm_bus_if));
    sbm_asserts #(.AD_W(SBM_AD_W)) u_sbm_asserts (.i_clock(i_clock), .i_reset(i_reset),
        .proc_oe(u_sbm_bus_if.proc_oe), .proc_valid_n(u_sbm_bus_if.proc_valid_n),
        .release_n(u_sbm_bus_if.release_n), .agent_oe(u_sbm_bus_if.agent_oe),
        .agent_valid_n(u_sbm_bus_if.agent_valid_n), .ext_request_n(u_sbm_bus_if.ext_request_n),
        .read_ready_n(u_sbm_bus_if.read_ready_n), .write_ready_n(u_sbm_bus_if.write_ready_n),
        .sys_addr_data_bus(u_sbm_bus_if.sys_addr_data_bus), .sys_command_bus(u_sbm_bus_if.sys_command_bus));

    always #5 i_clock = ~i_clock;

    // Pulses are latched here so no scenario can miss one
    always @(posedge i_clock) begin
        if (u_sbm_bus_if.release_n === 1'b0) rel_cnt++;
        if (u_sbm_bus_if.ext_request_n === 1'b0) arb_cnt++;
        if (preq_valid === 1'b1) preq_t.push_back($time);
        if (rd_valid === 1'b1) begin
            rd_cnt++;
            last_rd = rd_data;
        end
        if (pwr_valid === 1'b1) begin
            wr_cnt++;
            last_wr = pwr_data;
        end
        if (pext_valid === 1'b1) begin
            ext_cnt++;
            last_ext = pext_data;
        end
    end

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Write mode is only taken while reset is high
    task automatic do_reset(input sbm_wmode_t m, input int cyc);
        i_reset <= 1'b1;
        wmode <= m;
        repeat (cyc) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
    endtask

    // Leaves the request line up so the caller can chain the next one
    task automatic core_req(input logic wr, input logic [SBM_AD_W-1:0] a, input logic [SBM_AD_W-1:0] d);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        do begin
            @(negedge i_clock);
            n++;
        end while (req_taken !== 1'b1 && n < 60);
        chk(n < 60, "request not taken");
        @(posedge i_clock);
    endtask

    initial begin
        #100000;
        fails++;
        stop_test();
    end

    initial begin
        do_reset(SBM_WM_COMPAT, 20);
        @(negedge i_clock);
        chk(u_sbm_bus_if.proc_oe === 1'b1 && u_sbm_bus_if.release_n === 1'b1 && master === 1'b1
            && u_sbm_bus_if.proc_valid_n === 1'b1 && u_sbm_bus_if.agent_oe === 1'b0, "reset state");
        @(posedge i_clock);
        wr_acc <= 1'b0;
        repeat (3) @(posedge i_clock);
        core_req(1'b1, 64'h40, 64'h1111_2222_3333_4444);
        req_valid <= 1'b0;
        repeat (8) begin
            @(negedge i_clock);
            chk(u_sbm_bus_if.proc_valid_n === 1'b0 && preq_t.size() == 0, "write issued early");
        end
        @(posedge i_clock);
        wr_acc <= 1'b1;
        for (k = 0; k < 40 && wr_cnt == 0; k++) @(posedge i_clock);
        chk(preq_addr === 64'h40 && preq_write === 1'b1 && last_wr === 64'h1111_2222_3333_4444, "write");
        for (int m = 0; m < 3; m++) begin
            do_reset(wm[m], 2);
            preq_t.delete();
            w0 = wr_cnt;
            core_req(1'b1, 64'h100 + m, 64'hA000 + m);
            core_req(1'b1, 64'h200 + m, 64'hB000 + m);
            req_valid <= 1'b0;
            for (k = 0; k < 40 && wr_cnt < w0 + 2; k++) @(posedge i_clock);
            chk(preq_t.size() == 2 && preq_t[1] - preq_t[0] == gap[m] * 10, "write spacing");
            chk(last_wr === 64'hB000 + m && preq_addr === 64'h200 + m, "second write");
        end
        for (int j = 0; j < 2; j++) begin
            do_reset(SBM_WM_PIPE, 2);
            r0 = rd_cnt;
            rl0 = rel_cnt;
            a0 = arb_cnt;
            core_req(1'b0, 64'h300, '0);
            req_write <= j[0];
            req_addr <= 64'h400;
            repeat (6) begin
                @(negedge i_clock);
                chk(req_taken !== 1'b1, "request while read pending");
            end
            chk(rel_cnt == rl0 + 1 && master === 1'b0 && preq_write === 1'b0, "read release");
            chk(prd_pend === 1'b1 && ard_pend === 1'b1 && preq_cmd === 8'h0F, "read pending");
            @(posedge i_clock);
            rsp_valid <= 1'b1;
            rsp_data <= 64'hC0DE + j;
            for (k = 0; k < 40 && rsp_taken !== 1'b1; k++) @(negedge i_clock);
            @(posedge i_clock);
            rsp_valid <= 1'b0;
            for (k = 0; k < 40 && req_taken !== 1'b1; k++) @(negedge i_clock);
            chk(k < 40 && rd_cnt == r0 + 1 && last_rd === 64'hC0DE + j, "read response");
            chk(arb_cnt == a0, "response arbitrated");
            @(posedge i_clock);
            req_valid <= 1'b0;
        end
        do_reset(SBM_WM_COMPAT, 2);
        e0 = ext_cnt;
        rl0 = rel_cnt;
        ext_valid <= 1'b1;
        ext_data <= 64'h5A5A;
        for (k = 0; k < 40 && ext_taken !== 1'b1; k++) @(negedge i_clock);
        @(posedge i_clock);
        ext_valid <= 1'b0;
        for (k = 0; k < 40 && (ext_cnt == e0 || master !== 1'b1); k++) @(posedge i_clock);
        chk(k < 40 && last_ext === 64'h5A5A && rel_cnt == rl0 + 1, "external write");
        stop_test();
    end
endmodule
`default_nettype wire
